// [t2rc_edge_if.sv]
// Synchronised level and rising-edge pulse of a slow source
`timescale 1ns/100ps
`default_nettype none
interface t2rc_edge_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : t2rc_edge_if
`default_nettype wire

// [t2rc_edge_sync.sv]
// Two-flop synchroniser with rising-edge detector
`timescale 1ns/100ps
`default_nettype none
module t2rc_edge_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  t2rc_edge_if.src  edge_out
);
  logic meta;
  logic sync;
  logic prev;

  // Second flop alone reads the first
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

  // One pulse per source rising edge
  assign edge_out.level = sync;
  assign edge_out.rise  = sync & ~prev;
endmodule : t2rc_edge_sync
`default_nettype wire

// [t2rc_pkg.sv]
// Constants shared by the reload and capture timer
package t2rc_pkg;
  localparam int         BYTE_W      = 8;
  localparam logic [7:0] BYTE_MAX    = 8'hff;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] BYTE_ONE    = 8'h01;
  // Control register field positions
  localparam int         CTL_HOVF    = 7;
  localparam int         CTL_LOVF    = 6;
  localparam int         CTL_LIEN    = 5;
  localparam int         CTL_CEN     = 4;
  localparam int         CTL_SPLIT   = 3;
  localparam int         CTL_RUN     = 2;
  localparam int         CTL_XCLK_HI = 1;
  localparam int         CTL_XCLK_LO = 0;
  // External clock select codes
  localparam logic [1:0] XCLK_DIV12  = 2'h0;
  localparam logic [1:0] XCLK_RTC    = 2'h1;
  localparam logic [1:0] XCLK_RSVD   = 2'h2;
  localparam logic [1:0] XCLK_CMP    = 2'h3;
  // Prescaler ratios
  localparam int         SYS_DIV     = 12;
  localparam int         RTC_DIV     = 8;
  localparam int         SYS_DIV_W   = 4;
  localparam int         RTC_DIV_W   = 3;
endpackage : t2rc_pkg

// [t2rc_timer.sv]
// Sixteen-bit or split auto-reload timer with capture mode
`timescale 1ns/100ps
`default_nettype none
module t2rc_timer
  import t2rc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_count_low,
  input  wire logic        wr_count_high,
  input  wire logic        wr_reload_low,
  input  wire logic        wr_reload_high,
  input  wire logic        wr_control,
  input  wire logic        high_byte_clock_sel,
  input  wire logic        low_byte_clock_sel,
  input  wire logic        timer_irq_enable,
  input  wire logic        rtc_clock,
  input  wire logic        comparator0,
  output logic      [7:0]  count_low_byte,
  output logic      [7:0]  count_high_byte,
  output logic      [7:0]  reload_low_byte,
  output logic      [7:0]  reload_high_byte,
  output logic      [7:0]  timer_control_reg,
  output logic             irq_request
);
  t2rc_edge_if rtc_if ();
  t2rc_edge_if cmp_if ();
  logic [SYS_DIV_W-1:0] sys_div_cnt;
  logic [RTC_DIV_W-1:0] rtc_div_cnt;

  // Synchronise both slow sources
  t2rc_edge_sync u_rtc_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (rtc_clock),
    .edge_out (rtc_if.src)
  );
  t2rc_edge_sync u_cmp_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (comparator0),
    .edge_out (cmp_if.src)
  );

  // Control fields
  wire       split    = timer_control_reg[CTL_SPLIT];
  wire       run      = timer_control_reg[CTL_RUN];
  wire       cen      = timer_control_reg[CTL_CEN];
  wire       lien     = timer_control_reg[CTL_LIEN];
  wire [1:0] xclk     = timer_control_reg[CTL_XCLK_HI:CTL_XCLK_LO];

  // Prescaler ticks
  wire div12_tick = (sys_div_cnt == SYS_DIV_W'(SYS_DIV - 1));
  wire rtc8_tick  = rtc_if.rise && (rtc_div_cnt == RTC_DIV_W'(RTC_DIV - 1));

  // External clock chosen by field; reserved code never ticks
  wire ext_tick = (xclk == XCLK_DIV12) ? div12_tick :
                  (xclk == XCLK_RTC)   ? rtc8_tick  :
                  (xclk == XCLK_CMP)   ? cmp_if.rise : 1'b0;
  wire tick_l   = low_byte_clock_sel  ? 1'b1 : ext_tick;
  wire tick_h   = high_byte_clock_sel ? 1'b1 : ext_tick;

  // Capture trigger picked by upper select bit
  wire cap_evt  = cen && (xclk[CTL_XCLK_HI] ? cmp_if.rise : rtc8_tick);

  // Advance and wrap decode
  wire l_full   = (count_low_byte == BYTE_MAX);
  wire h_full   = (count_high_byte == BYTE_MAX);
  wire adv_l    = split ? tick_l : (run && tick_l);
  wire adv_h    = split ? (run && tick_h) : (run && tick_l && l_full);
  wire wrap_l   = adv_l && l_full;
  wire wrap_h   = adv_h && h_full;
  wire wrap16   = !split && wrap_l && h_full;
  wire reload_l = !cen && (split ? wrap_l : wrap16);
  wire reload_h = !cen && wrap_h;

  // Next count values; software write wins over counting
  wire [7:0] next_low  = wr_count_low  ? wdata :
                         reload_l      ? reload_low_byte :
                         adv_l         ? 8'(count_low_byte + BYTE_ONE) : count_low_byte;
  wire [7:0] next_high = wr_count_high ? wdata :
                         reload_h      ? reload_high_byte :
                         adv_h         ? 8'(count_high_byte + BYTE_ONE) : count_high_byte;

  // Flag sets; a hardware set beats a same-cycle clear
  wire hov_set  = (!cen && wrap_h) || cap_evt;
  wire lov_set  = wrap_l;
  wire next_hov = hov_set || (wr_control ? wdata[CTL_HOVF] : timer_control_reg[CTL_HOVF]);
  wire next_lov = lov_set || (wr_control ? wdata[CTL_LOVF] : timer_control_reg[CTL_LOVF]);
  wire [5:0] next_cfg = wr_control ? wdata[CTL_LIEN:0] : timer_control_reg[CTL_LIEN:0];
  wire next_lien = next_cfg[CTL_LIEN];
  wire next_irq  = timer_irq_enable && (next_hov || (next_lien && next_lov));

  // Prescaler counters
  always_ff @(posedge clk) begin
    if (reset) begin
      sys_div_cnt <= '0;
      rtc_div_cnt <= '0;
    end else begin
      sys_div_cnt <= div12_tick ? '0 : SYS_DIV_W'(sys_div_cnt + 1'b1);
      if (rtc_if.rise) begin
        rtc_div_cnt <= RTC_DIV_W'(rtc_div_cnt + 1'b1);
      end
    end
  end

  // Count, control and interrupt registers
  always_ff @(posedge clk) begin
    if (reset) begin
      count_low_byte    <= BYTE_RESET;
      count_high_byte   <= BYTE_RESET;
      timer_control_reg <= CTL_RESET;
      irq_request       <= 1'b0;
    end else begin
      count_low_byte    <= next_low;
      count_high_byte   <= next_high;
      timer_control_reg <= {next_hov, next_lov, next_cfg};
      irq_request       <= next_irq;
    end
  end

  // Reload pair; a capture beats a software write
  always_ff @(posedge clk) begin
    if (reset) begin
      reload_low_byte  <= BYTE_RESET;
      reload_high_byte <= BYTE_RESET;
    end else if (cap_evt) begin
      reload_low_byte  <= count_low_byte;
      reload_high_byte <= count_high_byte;
    end else begin
      if (wr_reload_low) begin
        reload_low_byte <= wdata;
      end
      if (wr_reload_high) begin
        reload_high_byte <= wdata;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire no_cnt_wr = !wr_count_low && !wr_count_high;

  sequence s_cmp_edge;
    !cmp_if.level ##1 cmp_if.level;
  endsequence
  sequence s_single_pulse;
    cmp_if.rise ##1 !cmp_if.rise;
  endsequence

  property p_wrap16;
    (wrap16 && !cen && no_cnt_wr) |=> (count_low_byte == $past(reload_low_byte))
      && (count_high_byte == $past(reload_high_byte)) && timer_control_reg[CTL_HOVF];
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload");

  property p_irq_high;
    ($past(timer_irq_enable) && timer_control_reg[CTL_HOVF]) |-> irq_request;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("overflow raised no irq");

  property p_irq_low;
    ($past(timer_irq_enable) && lien && timer_control_reg[CTL_LOVF]) |-> irq_request;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low wrap raised no irq");

  property p_irq_off;
    !$past(timer_irq_enable) |-> !irq_request;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  property p_split_low_free;
    (split && !run && tick_l && !l_full && !wr_count_low && !wr_control)
      |=> count_low_byte == 8'($past(count_low_byte) + BYTE_ONE);
  endproperty
  a_split_low_free: assert property (p_split_low_free) else $error("low byte stalled");

  property p_split_reload;
    (split && !cen && wrap_l && !wr_count_low) |=> count_low_byte == $past(reload_low_byte)
      && timer_control_reg[CTL_LOVF];
  endproperty
  a_split_reload: assert property (p_split_reload) else $error("split low reload");

  property p_hold;
    (!split && !run && no_cnt_wr) |=> $stable(count_low_byte) && $stable(count_high_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");

  property p_sticky;
    (timer_control_reg[CTL_HOVF] && !wr_control) |=> timer_control_reg[CTL_HOVF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

  property p_capture;
    cap_evt |=> (reload_low_byte == $past(count_low_byte))
      && (reload_high_byte == $past(count_high_byte)) && timer_control_reg[CTL_HOVF];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");

  property p_cap_no_reload;
    (cen && !split && wrap16 && no_cnt_wr) |=> count_low_byte == BYTE_RESET
      && count_high_byte == BYTE_RESET;
  endproperty
  a_cap_no_reload: assert property (p_cap_no_reload) else $error("reload in capture");

  property p_edge_once;
    s_cmp_edge |-> s_single_pulse;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge pulse wrong");

  property p_div12;
    div12_tick |-> ##12 div12_tick;
  endproperty
  a_div12: assert property (p_div12) else $error("divide by 12 spacing");

  // Eighth synchronised clock rise must capture the count and set the flag
  property p_rtc_trigger;
    (cen && !xclk[CTL_XCLK_HI] && rtc_if.rise && (rtc_div_cnt == RTC_DIV_W'(RTC_DIV - 1)))
      |=> timer_control_reg[CTL_HOVF] && (reload_low_byte == $past(count_low_byte));
  endproperty
  a_rtc_trigger: assert property (p_rtc_trigger) else $error("rtc capture trigger");
endmodule : t2rc_timer
`default_nettype wire

// [t2rc_timer_tb.sv]
// Self-checking bench for the reload and capture timer
`timescale 1ns/100ps
`default_nettype none
module t2rc_timer_tb
  import t2rc_pkg::*;
;
  logic        clk;
  logic        reset;
  logic [7:0]  wdata;
  logic [4:0]  wr_vec;
  logic        hsel;
  logic        lsel;
  logic        irq_en;
  logic        rtc;
  logic        cmp;
  logic        ok;
  wire logic [7:0] cl;
  wire logic [7:0] ch;
  wire logic [7:0] rl;
  wire logic [7:0] rh;
  wire logic [7:0] ctl;
  wire logic       irq;
  int          fails;
  int          total_checks;
  int          seed;
  int          cycles;
  logic [7:0]  q_id[$];
  logic [15:0] q_exp[$];
  event        sample_ev;

  t2rc_timer DUT (
    .clk(clk), .reset(reset), .wdata(wdata),
    .wr_count_low(wr_vec[0]), .wr_count_high(wr_vec[1]),
    .wr_reload_low(wr_vec[2]), .wr_reload_high(wr_vec[3]), .wr_control(wr_vec[4]),
    .high_byte_clock_sel(hsel), .low_byte_clock_sel(lsel),
    .timer_irq_enable(irq_en), .rtc_clock(rtc), .comparator0(cmp),
    .count_low_byte(cl), .count_high_byte(ch), .reload_low_byte(rl),
    .reload_high_byte(rh), .timer_control_reg(ctl), .irq_request(irq)
  );

  // System clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Records an expectation for the output watcher
  task note(input logic [7:0] id, input logic [15:0] e);
    q_id.push_back(id);
    q_exp.push_back(e);
    -> sample_ev;
    #1;
  endtask : note

  // One write strobe: 0 count low, 1 count high, 2 reload low, 3 reload high, 4 control
  task wr(input int which, input logic [7:0] v);
    @(negedge clk);
    wdata  = v;
    wr_vec = 5'h01 << which;
    @(negedge clk);
    wr_vec = 5'h00;
  endtask : wr

  // Bounded wait for a control bit to be set by hardware
  task wait_flag(input int b);
    ok = 1'b0;
    repeat (400) begin
      @(negedge clk);
      if (ctl[b] === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask : wait_flag

  // Slow source rising edges, several system clocks apart
  task pulse(input logic use_cmp, input int n);
    repeat (n) begin
      @(negedge clk);
      if (use_cmp) cmp = 1'b1;
      else rtc = 1'b1;
      repeat (2) @(negedge clk);
      rtc = 1'b0;
      cmp = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask : pulse

  // Output watcher: takes the oldest expectation when a result is due
  initial forever begin
    @(sample_ev);
    while (q_id.size() > 0) begin
      case (q_id.pop_front())
        0: check("count_low_byte", {8'h00, cl}, q_exp.pop_front());
        1: check("count_high_byte", {8'h00, ch}, q_exp.pop_front());
        2: check("reload_low_byte", {8'h00, rl}, q_exp.pop_front());
        3: check("reload_high_byte", {8'h00, rh}, q_exp.pop_front());
        4: check("timer_control_reg", {8'h00, ctl}, q_exp.pop_front());
        5: check("irq_request", {15'h0000, irq}, q_exp.pop_front());
        6: check("condition", {15'h0000, ok}, q_exp.pop_front());
        default: check("high_overflow_flag", {15'h0000, ctl[CTL_HOVF]}, q_exp.pop_front());
      endcase
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    logic [15:0] r;
    logic [15:0] d;
    int          code;
    seed = 44; fails = 0; total_checks = 0; cycles = 0; ok = 1'b0;
    reset = 1'b1; wdata = 8'h00; wr_vec = 5'h00; hsel = 1'b1; lsel = 1'b1;
    irq_en = 1'b0; rtc = 1'b0; cmp = 1'b0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 6; i++) note(i[7:0], 16'h0000);
    // Byte read-back with random values
    r = $random(seed);
    wr(0, r[7:0]); wr(1, r[15:8]); wr(2, r[7:0]); wr(3, r[15:8]);
    note(0, r[7:0]); note(1, r[15:8]); note(2, r[7:0]); note(3, r[15:8]);
    // Sixteen-bit wrap reloads the pair and sets the high flag
    wr(1, 8'hff); wr(0, 8'hfe); wr(4, 8'h04);
    wait_flag(CTL_HOVF);
    note(6, 1); note(0, r[7:0]); note(1, r[15:8]);
    note(5, 0);
    irq_en = 1'b1;
    repeat (2) @(negedge clk);
    note(5, 1);
    // Low-byte wrap interrupt with and without its enable
    wr(4, 8'h20); wr(0, 8'hfe); wr(1, 8'h00); wr(4, 8'h24);
    wait_flag(CTL_LOVF);
    note(6, 1); note(1, 8'h01); note(7, 0); note(5, 1);
    wr(4, 8'h00); wr(0, 8'hfe); wr(4, 8'h04);
    wait_flag(CTL_LOVF);
    note(6, 1); note(5, 0);
    // Run bit clear holds the count
    wr(4, 8'h00); wr(0, 8'h5a);
    repeat (20) @(negedge clk);
    note(0, 8'h5a);
    // Split mode: low byte free-running, high byte gated by run bit
    r = $random(seed);
    wr(2, r[7:0]); wr(3, r[15:8]); wr(1, 8'h55); wr(0, 8'hf0); wr(4, 8'h08);
    wait_flag(CTL_LOVF);
    note(6, 1); note(0, r[7:0]); note(7, 0);
    note(1, 8'h55);
    wr(1, 8'hfd); wr(4, 8'h0c);
    wait_flag(CTL_HOVF);
    note(6, 1); note(1, r[15:8]); note(5, 1);
    repeat (30) @(negedge clk);
    note(7, 1);
    // Stop the high byte first so no high-byte wrap can race the clearing write
    wr(4, 8'h88);
    wr(4, 8'h00);
    note(7, 0);
    // External sources: one step per edge, rtc divided by eight, code 10 idle
    lsel = 1'b0;
    for (code = 1; code < 4; code++) begin
      wr(4, code[7:0]); wr(0, 8'h00); wr(1, 8'h00); wr(4, 8'h04 | code[7:0]);
      pulse(1'b0, 16);
      pulse(1'b1, 5);
      repeat (6) @(negedge clk);
      note(0, (code == 1) ? 16'd2 : (code == 3) ? 16'd5 : 16'd0);
    end
    wr(4, 8'h00); wr(0, 8'h00); wr(4, 8'h04);
    repeat (120) @(negedge clk);
    ok = (cl >= 8'h09) && (cl <= 8'h0b);
    note(6, 1);
    // Capture on each trigger code, counter runs through
    lsel = 1'b1;
    for (code = 0; code < 4; code++) begin
      wr(4, 8'h14 | code[7:0]);
      fork
        pulse(code[1], (code < 2) ? 8 : 1);
        begin
          wait_flag(CTL_HOVF);
          d = {ch, cl} - {rh, rl};
        end
      join
      ok = ok && (d <= 16'd2);
      note(6, 1);
      note(5, 1);
    end
    test_done();
  end
endmodule : t2rc_timer_tb
`default_nettype wire
